/* File: core/pcs_pkg.sv */
// constants and types shared by the position compare strobe
package pcs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register bus geometry
	localparam int              PCS_ADDR_W             = 7;
	localparam int              PCS_DATA_W             = 32;
	localparam int              PCS_REPEAT_W           = 24;
	localparam int              PCS_MICROSTEP_RESOLUTION_W             = 4;

	// register offsets
	localparam logic [6:0]      PCS_GLOBAL_CONFIG_ADDR = 7'h00;
	localparam logic [6:0]      PCS_MATCH_ADDR         = 7'h10;
	localparam logic [6:0]      PCS_REPEAT_ADDR        = 7'h11;

	// field positions, values after reset and the lowest repeat for periodic mode
	localparam int              PCS_GCFG_PULSE_EN_BIT  = 13;
	localparam logic            PCS_GCFG_PULSE_EN_RST  = 1'b0;
	localparam logic [31:0]     PCS_MATCH_RESET        = 32'hFFFFFFFF;
	localparam logic [23:0]     PCS_REPEAT_RESET       = 24'h000000;
	localparam logic [23:0]     PCS_REPEAT_PERIODIC    = 24'h000002;

	// resolution code of full steps, the coarsest scaling
	localparam logic [3:0]      PCS_MICROSTEP_RESOLUTION_FULLSTEP      = 4'h8;

	// division step count and catch-up distance of the residue engine
	localparam logic [5:0]      PCS_DIV_STEPS          = 6'h20;
	localparam logic [31:0]     PCS_CATCHUP_LIMIT      = 32'h00000100;

	////////////////////////////////////////////////////////////////////////////
	// residue engine states
	typedef enum logic [1:0] {
		PCS_PH_IDLE,
		PCS_PH_DIVIDE,
		PCS_PH_TRACK
	} pcs_phase_state_t;

endpackage

/* File: core/pcs_phase_if.sv */
// signals between the strobe control and its residue engine
`timescale 1ns/1ns
interface pcs_phase_if;
	logic        restart;  // pulse: recompute residue from scratch
	logic [31:0] diff;     // actual position minus base position
	logic [31:0] period;   // scaled repeat distance, at least 2
	logic        aligned;  // position sits on a multiple of period
	logic        tracking; // residue is valid

	modport ctl (output restart, output diff, output period, input aligned, input tracking);
	modport phs (input restart, input diff, input period, output aligned, output tracking);
endinterface

/* File: core/pcs_phase.sv */
// residue engine: position offset modulo repeat distance, both directions
`timescale 1ns/1ns
module pcs_phase
	import pcs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	pcs_phase_if.phs  ph
);

	pcs_phase_state_t st_q;
	logic [31:0]      period_q;
	logic [31:0]      tracked_q;
	logic [31:0]      residue_q;
	logic [31:0]      mag_q;
	logic [31:0]      rem_q;
	logic             neg_q;
	logic [5:0]       cnt_q;
	logic [32:0]      shifted;
	logic [31:0]      delta;
	logic             jump;
	logic [31:0]      tracked_d;
	logic [31:0]      residue_d;

	////////////////////////////////////////////////////////////////////////////
	// one restoring division step per cycle
	assign shifted = {rem_q, mag_q[31]};
	assign delta   = ph.diff - tracked_q;
	assign jump    = delta[31] ? ((32'h0 - delta) > PCS_CATCHUP_LIMIT) : (delta > PCS_CATCHUP_LIMIT);

	// tracked offset steps one unit toward the live offset, residue wraps
	always_comb begin
		tracked_d = tracked_q;
		residue_d = residue_q;
		if (delta != 32'h0 && !delta[31]) begin
			tracked_d = tracked_q + 32'h1;
			residue_d = (residue_q == period_q - 32'h1) ? 32'h0 : residue_q + 32'h1;
		end else if (delta[31]) begin
			tracked_d = tracked_q - 32'h1;
			residue_d = (residue_q == 32'h0) ? period_q - 32'h1 : residue_q - 32'h1;
		end
	end

	// strobe on a whole multiple of the period from the base
	assign ph.aligned  = (st_q == PCS_PH_TRACK) && (tracked_d == ph.diff) && (residue_d == 32'h0);
	assign ph.tracking = (st_q == PCS_PH_TRACK);

	////////////////////////////////////////////////////////////////////////////
	// state sequence: restart, divide, track
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= PCS_PH_IDLE;
		end else begin
			case (st_q)
				PCS_PH_IDLE:   st_q <= ph.restart ? PCS_PH_DIVIDE : PCS_PH_IDLE;
				PCS_PH_DIVIDE: begin
					if (ph.restart)
						st_q <= PCS_PH_DIVIDE;
					else if (cnt_q == PCS_DIV_STEPS - 6'h1)
						st_q <= PCS_PH_TRACK;
				end
				PCS_PH_TRACK:  st_q <= (ph.restart || jump) ? PCS_PH_DIVIDE : PCS_PH_TRACK;
				default:       st_q <= PCS_PH_IDLE;
			endcase
		end
	end

	// divider datapath and residue tracking
	always_ff @(posedge clk) begin
		if (rst) begin
			period_q  <= 32'h2;
			tracked_q <= 32'h0;
			residue_q <= 32'h0;
			mag_q     <= 32'h0;
			rem_q     <= 32'h0;
			neg_q     <= 1'b0;
			cnt_q     <= 6'h0;
		end else if (ph.restart || (st_q == PCS_PH_TRACK && jump)) begin
			// negative offsets divide by magnitude, then fold back
			period_q  <= ph.period;
			tracked_q <= ph.diff;
			neg_q     <= ph.diff[31];
			mag_q     <= ph.diff[31] ? (32'h0 - ph.diff) : ph.diff;
			rem_q     <= 32'h0;
			cnt_q     <= 6'h0;
		end else if (st_q == PCS_PH_DIVIDE) begin
			mag_q <= {mag_q[30:0], 1'b0};
			cnt_q <= cnt_q + 6'h1;
			if (shifted >= {1'b0, period_q})
				rem_q <= 32'(shifted - {1'b0, period_q});
			else
				rem_q <= shifted[31:0];
			if (cnt_q == PCS_DIV_STEPS - 6'h1) begin
				if (shifted >= {1'b0, period_q})
					residue_q <= (neg_q && shifted != {1'b0, period_q}) ?
						32'(33'(period_q) - (shifted - {1'b0, period_q})) : 32'(shifted - {1'b0, period_q});
				else
					residue_q <= (neg_q && shifted != 33'h0) ? 32'(33'(period_q) - shifted) : shifted[31:0];
			end
		end else if (st_q == PCS_PH_TRACK) begin
			tracked_q <= tracked_d;
			residue_q <= residue_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reference residue for checking, signed modulo folded positive
	logic signed [63:0] ref_m;
	logic        [31:0] ref_res;
	always_comb begin
		ref_m   = $signed({{32{tracked_q[31]}}, tracked_q}) % $signed({32'h0, period_q});
		ref_res = ref_m[63] ? 32'(ref_m + $signed({32'h0, period_q})) : ref_m[31:0];
	end

	a_residue_true: assert property (@(posedge clk) disable iff (rst)
		st_q == PCS_PH_TRACK |-> residue_q == ref_res)
		else $error("residue disagrees with offset modulo period");

	a_divide_done: assert property (@(posedge clk) disable iff (rst)
		(st_q == PCS_PH_DIVIDE && cnt_q == PCS_DIV_STEPS - 6'h1 && !ph.restart) |=> st_q == PCS_PH_TRACK)
		else $error("division did not end after its step count");

	c_negative_hit: cover property (@(posedge clk) disable iff (rst) ph.aligned && ph.diff[31]);

endmodule // pcs_phase

/* File: core/pcs_top.sv */
// position compare strobe for one axis: registers, match and periodic pulse
`timescale 1ns/1ns
module pcs_top
	import pcs_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	input  wire logic                  REG_WR_EN,
	input  wire logic [PCS_ADDR_W-1:0] REG_ADDR,
	input  wire logic [PCS_DATA_W-1:0] REG_WDATA,
	output logic      [PCS_DATA_W-1:0] REG_RDATA,
	input  wire logic [31:0]           ACTUAL_POSITION,
	input  wire logic [PCS_MICROSTEP_RESOLUTION_W-1:0] MICROSTEP_RESOLUTION,
	output logic                       POSITION_PULSE,
	output logic                       DIAGNOSTIC_PIN_ONE,
	output logic                       PERIODIC_READY
);

	logic                    gcfg_pulse_en_q;
	logic [31:0]             match_q;
	logic [PCS_REPEAT_W-1:0] repeat_q;
	logic [PCS_MICROSTEP_RESOLUTION_W-1:0]   microstep_resolution_q;
	logic                    periodic;
	logic [3:0]              shift;
	logic [31:0]             period_w;
	logic                    restart_q;
	logic                    exact_hit;
	logic                    pulse_d;
	logic                    wr_match;
	logic                    wr_repeat;
	logic                    periodic_q;
	logic                    settle;

	pcs_phase_if ph_if ();

	pcs_phase u_phase (
		.clk (CLK),
		.rst (SYS_RST),
		.ph  (ph_if.phs)
	);

	////////////////////////////////////////////////////////////////////////////
	// register writes at their printed offsets
	assign wr_match  = REG_WR_EN && (REG_ADDR == PCS_MATCH_ADDR);
	assign wr_repeat = REG_WR_EN && (REG_ADDR == PCS_REPEAT_ADDR);

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			gcfg_pulse_en_q <= PCS_GCFG_PULSE_EN_RST;
			match_q         <= PCS_MATCH_RESET;
			repeat_q        <= PCS_REPEAT_RESET;
		end else begin
			if (REG_WR_EN && REG_ADDR == PCS_GLOBAL_CONFIG_ADDR)
				gcfg_pulse_en_q <= REG_WDATA[PCS_GCFG_PULSE_EN_BIT];
			if (wr_match)
				match_q <= REG_WDATA;
			if (wr_repeat)
				repeat_q <= REG_WDATA[PCS_REPEAT_W-1:0];
		end
	end

	// readback, one cycle after the address; unmapped reads zero
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 32'h0;
		end else begin
			case (REG_ADDR)
				PCS_GLOBAL_CONFIG_ADDR: REG_RDATA <= 32'(gcfg_pulse_en_q) << PCS_GCFG_PULSE_EN_BIT;
				PCS_MATCH_ADDR:         REG_RDATA <= match_q;
				PCS_REPEAT_ADDR:        REG_RDATA <= {8'h0, repeat_q};
				default:                REG_RDATA <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode and period: repeat scaled up from the chosen resolution
	assign periodic = (repeat_q >= PCS_REPEAT_PERIODIC);
	assign shift    = (microstep_resolution_q > PCS_MICROSTEP_RESOLUTION_FULLSTEP) ? PCS_MICROSTEP_RESOLUTION_FULLSTEP : microstep_resolution_q;
	assign period_w = {8'h0, repeat_q} << shift;

	// offset from the compare base in absolute coordinates
	assign ph_if.diff    = ACTUAL_POSITION - match_q;
	assign ph_if.period  = periodic ? period_w : 32'h00000002; // never hand the divider a period below two
	assign ph_if.restart = restart_q;

	// residue is rebuilt when base, distance or scaling change, and on entry to periodic mode
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			microstep_resolution_q     <= 4'h0;
			periodic_q <= 1'b0;
			restart_q  <= 1'b0;
		end else begin
			microstep_resolution_q     <= MICROSTEP_RESOLUTION;
			periodic_q <= periodic;
			restart_q  <= periodic && (wr_match || wr_repeat || microstep_resolution_q != MICROSTEP_RESOLUTION || !periodic_q);
		end
	end

	// engine holds stale settings until the restart lands, so pulse and ready wait
	assign settle = restart_q || !periodic_q;

	////////////////////////////////////////////////////////////////////////////
	// pulse selection: exact equality or periodic alignment
	assign exact_hit = (ACTUAL_POSITION == match_q);
	assign pulse_d   = periodic ? (ph_if.aligned && !settle) : exact_hit;

	// pulse level and gated pin, both straight from flops
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			POSITION_PULSE     <= 1'b0;
			DIAGNOSTIC_PIN_ONE <= 1'b0;
			PERIODIC_READY     <= 1'b0;
		end else begin
			POSITION_PULSE     <= pulse_d;
			DIAGNOSTIC_PIN_ONE <= pulse_d && gcfg_pulse_en_q;
			PERIODIC_READY     <= periodic && ph_if.tracking && !settle;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_exact_match: assert property (
		!periodic && ACTUAL_POSITION == match_q |=> POSITION_PULSE)
		else $error("pulse missing on exact match");

	a_exact_release: assert property (
		!periodic && ACTUAL_POSITION != match_q |=> !POSITION_PULSE)
		else $error("pulse stays high after mismatch");

	a_low_repeat_exact: assert property (
		repeat_q < PCS_REPEAT_PERIODIC && ACTUAL_POSITION != match_q |=> !POSITION_PULSE)
		else $error("periodic pulse with repeat of zero or one");

	a_pin_gated: assert property (
		!gcfg_pulse_en_q |=> !DIAGNOSTIC_PIN_ONE)
		else $error("pin active with enable clear");

	a_pin_follows: assert property (
		gcfg_pulse_en_q |=> DIAGNOSTIC_PIN_ONE == POSITION_PULSE)
		else $error("pin does not follow pulse while enabled");

	a_match_write: assert property (
		wr_match |=> match_q == $past(REG_WDATA) ##1 REG_RDATA == match_q || $past(REG_ADDR) != PCS_MATCH_ADDR)
		else $error("compare value not stored");

	a_periodic_source: assert property (
		periodic && !wr_repeat && !ph_if.aligned |=> !POSITION_PULSE)
		else $error("periodic pulse without alignment");

	a_periodic_rebuild: assert property (
		periodic && (wr_match || wr_repeat) |=> restart_q ##1 !PERIODIC_READY)
		else $error("residue not rebuilt after setting change");

	a_periodic_hold: assert property (
		periodic && settle |=> !POSITION_PULSE)
		else $error("periodic pulse before residue rebuilt");

	a_exact_level: assert property (
		!$past(periodic) && POSITION_PULSE |-> $past(ACTUAL_POSITION) == $past(match_q))
		else $error("exact pulse without equal position");

	////////////////////////////////////////////////////////////////////////////
	// register bus checks
	a_enable_write: assert property (
		REG_WR_EN && REG_ADDR == PCS_GLOBAL_CONFIG_ADDR
		|=> gcfg_pulse_en_q == $past(REG_WDATA[PCS_GCFG_PULSE_EN_BIT]))
		else $error("pin enable not stored");

	a_enable_read: assert property (
		REG_ADDR == PCS_GLOBAL_CONFIG_ADDR |=> REG_RDATA == (32'($past(gcfg_pulse_en_q)) << PCS_GCFG_PULSE_EN_BIT))
		else $error("config readback wrong");

	a_repeat_store: assert property (
		wr_repeat |=> repeat_q == $past(REG_WDATA[PCS_REPEAT_W-1:0]))
		else $error("repeat distance not stored");

	a_read_match: assert property (
		REG_ADDR == PCS_MATCH_ADDR |=> REG_RDATA == $past(match_q))
		else $error("compare readback wrong");

	a_read_repeat: assert property (
		REG_ADDR == PCS_REPEAT_ADDR |=> REG_RDATA == {8'h00, $past(repeat_q)})
		else $error("repeat readback wrong");

	////////////////////////////////////////////////////////////////////////////
	// residue rebuild checks
	a_microstep_resolution_rebuild: assert property (
		periodic && microstep_resolution_q != MICROSTEP_RESOLUTION |=> restart_q)
		else $error("residue not rebuilt after resolution change");

	a_entry_rebuild: assert property (
		periodic && !periodic_q |=> restart_q)
		else $error("residue not rebuilt on entry to periodic mode");

	a_ready_settle: assert property (
		settle |=> !PERIODIC_READY)
		else $error("ready shown before residue rebuilt");

	c_exact_hit:    cover property (!periodic ##1 POSITION_PULSE);
	c_periodic_hit: cover property (periodic && PERIODIC_READY ##1 POSITION_PULSE);
	c_pin_high:     cover property (DIAGNOSTIC_PIN_ONE);
	c_rebuild:      cover property (restart_q ##1 !PERIODIC_READY);

endmodule // pcs_top

/* File: testbench/pcs_ramp_model.sv */
// ramp generator stand-in that walks the actual position toward a target
`timescale 1ns/1ns
module pcs_ramp_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [31:0] target,
	output logic      [31:0] position
);
	////////////////////////////////////////////////////////////////////////////
	// one unit per clock at most, so the residue engine never lags
	always_ff @(posedge clk) begin
		if (rst) begin
			position <= 32'h00000000;
		end else if ($signed(target) > $signed(position)) begin
			position <= position + 32'h00000001;
		end else if ($signed(target) < $signed(position)) begin
			position <= position - 32'h00000001;
		end
	end
endmodule // pcs_ramp_model

/* File: testbench/pcs_top_test.sv */
// self-checking bench of the position compare strobe
`timescale 1ns/1ns
module pcs_top_test;
	import pcs_pkg::*;
	logic        CLK                  = 1'b0;
	logic        SYS_RST              = 1'b1;
	logic        REG_WR_EN            = 1'b0;
	logic [6:0]  REG_ADDR             = 7'h00;
	logic [31:0] REG_WDATA            = 32'h00000000;
	logic [31:0] REG_RDATA;
	logic [31:0] ACTUAL_POSITION;
	logic [3:0]  MICROSTEP_RESOLUTION = 4'h0;
	logic        POSITION_PULSE;
	logic        DIAGNOSTIC_PIN_ONE;
	logic        PERIODIC_READY;
	logic [31:0] target               = 32'h00000000;
	logic [31:0] cmp_v                = 32'hFFFFFFFF;
	logic [31:0] period_v             = 32'h00000000;
	logic        chk                  = 1'b0;
	logic        per_mode             = 1'b0;
	logic        en                   = 1'b0;
	logic        exp_q                = 1'b0;
	int          mismatches           = 0;
	int          samples_checked      = 0;
	int          cycles               = 0;

	////////////////////////////////////////////////////////////////////////////
	// design, position source and clock
	pcs_top i_pcs_top (.CLK(CLK), .SYS_RST(SYS_RST), .REG_WR_EN(REG_WR_EN), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ACTUAL_POSITION(ACTUAL_POSITION),
		.MICROSTEP_RESOLUTION(MICROSTEP_RESOLUTION), .POSITION_PULSE(POSITION_PULSE),
		.DIAGNOSTIC_PIN_ONE(DIAGNOSTIC_PIN_ONE), .PERIODIC_READY(PERIODIC_READY));
	pcs_ramp_model i_pcs_ramp_model (.clk(CLK), .rst(SYS_RST), .target(target), .position(ACTUAL_POSITION));
	always #10 CLK = ~CLK;

	////////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge CLK);
		REG_WR_EN <= 1'b1;
		REG_ADDR  <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WR_EN <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		@(posedge CLK);
		REG_ADDR <= a;
		@(posedge CLK);
		#1 cmp(REG_RDATA, exp);
	endtask

	// program compare, repeat, resolution and pin enable, then wait for the engine
	task automatic setup(input logic [31:0] c, input logic [23:0] r, input logic [3:0] m, input logic e);
		@(posedge CLK);
		chk                  <= 1'b0;
		MICROSTEP_RESOLUTION <= m;
		wr(PCS_MATCH_ADDR, c);
		wr(PCS_REPEAT_ADDR, {8'h00, r});
		wr(PCS_GLOBAL_CONFIG_ADDR, {18'h00000, e, 13'h0000});
		cmp_v    <= c;
		en       <= e;
		per_mode <= (r > 24'h000001);
		period_v <= {8'h00, r} << ((m > 4'h8) ? 4'h8 : m);
		repeat (40) @(negedge CLK);
		while (per_mode && PERIODIC_READY !== 1'b1) @(negedge CLK);
		cmp({31'h0, PERIODIC_READY}, {31'h0, per_mode});
		chk <= 1'b1;
	endtask

	task automatic move(input logic [31:0] t);
		@(posedge CLK);
		target <= t;
		while (ACTUAL_POSITION !== t) @(posedge CLK);
		repeat (2) @(posedge CLK);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// per-cycle pulse and pin monitor on the falling edge, expectation from position one cycle back
	always @(negedge CLK) begin
		if (chk && (!per_mode || PERIODIC_READY === 1'b1)) begin
			cmp({31'h0, POSITION_PULSE}, {31'h0, exp_q});
			cmp({31'h0, DIAGNOSTIC_PIN_ONE}, {31'h0, exp_q & en});
		end
		exp_q <= per_mode ? ((int'(ACTUAL_POSITION - cmp_v) % int'(period_v)) == 0) : (ACTUAL_POSITION === cmp_v);
	end

	// hang guard
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		rd(PCS_MATCH_ADDR, 32'hFFFFFFFF);
		rd(PCS_REPEAT_ADDR, 32'h00000000);
		rd(PCS_GLOBAL_CONFIG_ADDR, 32'h00000000);
		wr(PCS_REPEAT_ADDR, 32'hFF123456);
		rd(PCS_REPEAT_ADDR, 32'h00123456);
		wr(7'h05, 32'h12345678);
		rd(7'h05, 32'h00000000);
		wr(PCS_GLOBAL_CONFIG_ADDR, 32'hFFFFFFFF);
		rd(PCS_GLOBAL_CONFIG_ADDR, 32'h00002000);
		$display("test registers done");
		setup(32'hFFFFFFFB, 24'h000000, 4'h0, 1'b1);
		move(32'hFFFFFFF0);
		move(32'h00000008);
		setup(32'h00000004, 24'h000001, 4'h0, 1'b0);
		move(32'hFFFFFFF8);
		$display("test exact done");
		setup(32'h00000003, 24'h000003, 4'h0, 1'b1);
		move(32'h00000020);
		move(32'hFFFFFFE0);
		setup(32'h00000001, 24'h000002, 4'h1, 1'b1);
		move(32'h00000010);
		setup(32'hFFFFFF00, 24'h000002, 4'hC, 1'b1);
		move(32'hFFFFFC00);
		$display("test periodic done");
		results();
	end
endmodule // pcs_top_test
